// *** mssc_pkg.sv ***
// Package for the motor start/stop command arbitration block
package mssc_pkg;

    // ----------------------------------------------------------------
    // Control schemes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MSSC_MODE_SINGLE,
        MSSC_MODE_EDGE,
        MSSC_MODE_LEVEL,
        MSSC_MODE_CONFLICT
    } mssc_mode_t;

    // ----------------------------------------------------------------
    // Stop methods
    // ----------------------------------------------------------------
    localparam int MSSC_STOP_SEL_W = 2;
    localparam logic [MSSC_STOP_SEL_W-1:0] MSSC_STOP_COAST    = 2'h0;
    localparam logic [MSSC_STOP_SEL_W-1:0] MSSC_STOP_RAMP     = 2'h1;
    localparam logic [MSSC_STOP_SEL_W-1:0] MSSC_STOP_QUICK    = 2'h2;
    localparam logic [MSSC_STOP_SEL_W-1:0] MSSC_STOP_RESERVED = 2'h3;

    // ----------------------------------------------------------------
    // Codes, reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [15:0] MSSC_ERR_WIRING = 16'h6280;
    localparam logic [15:0] MSSC_ERR_NONE   = 16'h0000;
    localparam int          MSSC_SYNC_STAGES = 2;
    localparam int          MSSC_NUM_CMD     = 7;

    // ----------------------------------------------------------------
    // Command inputs after synchronisation
    // ----------------------------------------------------------------
    typedef struct packed {
        logic drive_enable;
        logic run_command;
        logic edge_start_cw;
        logic edge_start_ccw;
        logic level_run_cw;
        logic level_run_ccw;
        logic direction_invert;
    } mssc_cmd_t;

    // ----------------------------------------------------------------
    // Source assignment flags
    // ----------------------------------------------------------------
    typedef struct packed {
        logic edge_assigned;
        logic level_assigned;
    } mssc_cfg_t;

endpackage : mssc_pkg

// *** mssc_sync.sv ***
// Two-stage synchroniser for a group of command inputs
`timescale 1ns/1ps
`default_nettype none
module mssc_sync
    import mssc_pkg::*;
#(
    parameter int WIDTH = MSSC_NUM_CMD
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    // Refuse an empty group at elaboration
    if (WIDTH < 1)
    begin : g_width_check
        $error("mssc_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_reg <= '0;
            sync_o   <= '0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule : mssc_sync
`default_nettype wire

// *** mssc_core.sv ***
// Motor start/stop and direction command arbitration
`timescale 1ns/1ps
`default_nettype none
module mssc_core
    import mssc_pkg::*;
(
    input  wire logic                       CLK_SYS_I,
    input  wire logic                       RESET_N_I,
    input  wire logic                       DRIVE_ENABLE_I,
    input  wire logic                       RUN_COMMAND_I,
    input  wire logic                       EDGE_START_CW_I,
    input  wire logic                       EDGE_START_CCW_I,
    input  wire logic                       LEVEL_RUN_CW_I,
    input  wire logic                       LEVEL_RUN_CCW_I,
    input  wire logic                       DIRECTION_INVERT_I,
    input  wire logic                       EDGE_ASSIGNED_I,
    input  wire logic                       LEVEL_ASSIGNED_I,
    input  wire logic                       FAULT_ACTIVE_I,
    input  wire logic [MSSC_STOP_SEL_W-1:0] STOP_METHOD_SELECT_I,
    output var  logic                       DRIVE_OUTPUT_EN_O,
    output var  logic                       RUN_REQUEST_O,
    output var  logic                       DIR_CCW_O,
    output var  logic [MSSC_STOP_SEL_W-1:0] STOP_METHOD_O,
    output var  logic                       RUNNING_O,
    output var  logic                       STOP_ACTIVE_O,
    output var  logic                       DIR_REVERSED_O,
    output var  logic                       CONFIG_ERROR_O,
    output var  logic [15:0]                ERROR_CODE_O
);

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    mssc_cmd_t cmd_raw;
    mssc_cmd_t cmd;
    mssc_cmd_t cmd_prev_reg;
    mssc_cfg_t cfg;

    assign cmd_raw = '{drive_enable:     DRIVE_ENABLE_I,
                       run_command:      RUN_COMMAND_I,
                       edge_start_cw:    EDGE_START_CW_I,
                       edge_start_ccw:   EDGE_START_CCW_I,
                       level_run_cw:     LEVEL_RUN_CW_I,
                       level_run_ccw:    LEVEL_RUN_CCW_I,
                       direction_invert: DIRECTION_INVERT_I};
    assign cfg = '{edge_assigned: EDGE_ASSIGNED_I, level_assigned: LEVEL_ASSIGNED_I};

    mssc_sync #(
        .WIDTH (MSSC_NUM_CMD)
    ) u_sync (
        .clk_i     (CLK_SYS_I),
        .reset_n_i (RESET_N_I),
        .async_i   (cmd_raw),
        .sync_o    (cmd)
    );

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            cmd_prev_reg <= '0;
        else
            cmd_prev_reg <= cmd;
    end

    // ----------------------------------------------------------------
    // Mode and edge decode
    // ----------------------------------------------------------------
    mssc_mode_t mode;
    wire conflict    = cfg.edge_assigned & cfg.level_assigned;
    assign mode      = conflict              ? MSSC_MODE_CONFLICT :
                       cfg.edge_assigned     ? MSSC_MODE_EDGE :
                       cfg.level_assigned    ? MSSC_MODE_LEVEL :
                                               MSSC_MODE_SINGLE;
    wire enable      = cmd.run_command;
    wire enable_rise = cmd.run_command & ~cmd_prev_reg.run_command;
    wire cw_rise     = cmd.edge_start_cw & ~cmd_prev_reg.edge_start_cw;
    wire ccw_rise    = cmd.edge_start_ccw & ~cmd_prev_reg.edge_start_ccw;
    wire lcw_rise    = cmd.level_run_cw & ~cmd_prev_reg.level_run_cw;
    wire lccw_rise   = cmd.level_run_ccw & ~cmd_prev_reg.level_run_ccw;
    wire drive_ok    = cmd.drive_enable & ~FAULT_ACTIVE_I;

    // ----------------------------------------------------------------
    // Arbitration state
    // ----------------------------------------------------------------
    logic run_reg;
    logic run_next;
    logic ccw_reg;
    logic ccw_next;

    always_comb
    begin
        run_next = run_reg;
        ccw_next = ccw_reg;
        case (mode)
            MSSC_MODE_SINGLE:
            begin
                run_next = enable;
                ccw_next = 1'b0;
            end
            MSSC_MODE_EDGE:
            begin
                if (!enable)
                    run_next = 1'b0;
                else if (cw_rise && !ccw_rise && !enable_rise)
                begin
                    run_next = 1'b1;
                    ccw_next = 1'b0;
                end
                else if (ccw_rise && !cw_rise && !enable_rise)
                begin
                    run_next = 1'b1;
                    ccw_next = 1'b1;
                end
                // Inputs already high at enable give no edge: stay stopped
            end
            MSSC_MODE_LEVEL:
            begin
                if (!enable)
                    run_next = 1'b0;
                else if (!cmd.level_run_cw && !cmd.level_run_ccw)
                    run_next = 1'b0;
                else if (enable_rise)
                begin
                    // Exactly one high at enable starts; both high waits
                    run_next = cmd.level_run_cw ^ cmd.level_run_ccw;
                    ccw_next = cmd.level_run_ccw;
                end
                else if (lcw_rise && !lccw_rise)
                begin
                    run_next = 1'b1;
                    ccw_next = 1'b0;
                end
                else if (lccw_rise && !lcw_rise)
                begin
                    run_next = 1'b1;
                    ccw_next = 1'b1;
                end
                else if (!run_reg && (cmd.level_run_cw ^ cmd.level_run_ccw) &&
                         (cmd_prev_reg.level_run_cw & cmd_prev_reg.level_run_ccw))
                begin
                    run_next = 1'b1;
                    ccw_next = cmd.level_run_ccw;
                end
                else if (run_reg && !(ccw_reg ? cmd.level_run_ccw : cmd.level_run_cw))
                    ccw_next = ~ccw_reg; // Followed input dropped, other still held
            end
            default:
                run_next = 1'b0;
        endcase
        if (!drive_ok)
            run_next = 1'b0;
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            run_reg <= 1'b0;
            ccw_reg <= 1'b0;
        end
        else
        begin
            run_reg <= run_next;
            ccw_reg <= ccw_next;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    wire dir_out = ccw_next ^ cmd.direction_invert;

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            DRIVE_OUTPUT_EN_O <= 1'b0;
            RUN_REQUEST_O     <= 1'b0;
            DIR_CCW_O         <= 1'b0;
            STOP_METHOD_O     <= MSSC_STOP_COAST;
            RUNNING_O         <= 1'b0;
            STOP_ACTIVE_O     <= 1'b0;
            DIR_REVERSED_O    <= 1'b0;
            CONFIG_ERROR_O    <= 1'b0;
            ERROR_CODE_O      <= MSSC_ERR_NONE;
        end
        else
        begin
            DRIVE_OUTPUT_EN_O <= cmd.drive_enable;
            RUN_REQUEST_O     <= run_next;
            DIR_CCW_O         <= dir_out;
            STOP_METHOD_O     <= cmd.drive_enable ? STOP_METHOD_SELECT_I
                                                  : MSSC_STOP_COAST;
            RUNNING_O         <= run_next;
            STOP_ACTIVE_O     <= run_reg & ~run_next & cmd.drive_enable;
            DIR_REVERSED_O    <= run_next & dir_out;
            CONFIG_ERROR_O    <= conflict;
            ERROR_CODE_O      <= conflict ? MSSC_ERR_WIRING : MSSC_ERR_NONE;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_enable_lost;
        !cmd.run_command && (mode == MSSC_MODE_EDGE || mode == MSSC_MODE_LEVEL);
    endsequence

    property p_single_start;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (mode == MSSC_MODE_SINGLE && enable && drive_ok && !cmd.direction_invert)
            |=> RUN_REQUEST_O && !DIR_CCW_O;
    endproperty
    a_single_start: assert property (p_single_start) else $error("single run did not start cw");

    property p_single_stop;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (mode == MSSC_MODE_SINGLE && !enable) |=> !RUN_REQUEST_O;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("run low did not stop");

    property p_invert;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        1'b1 |=> DIR_CCW_O == ($past(ccw_next) ^ $past(cmd.direction_invert));
    endproperty
    a_invert: assert property (p_invert) else $error("direction not inverted");

    property p_edge_start;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (mode == MSSC_MODE_EDGE && enable && !enable_rise && drive_ok && ccw_rise && !cw_rise)
            |=> RUN_REQUEST_O && (DIR_CCW_O == !$past(cmd.direction_invert));
    endproperty
    a_edge_start: assert property (p_edge_start) else $error("ccw edge did not start");

    property p_enable_lost;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        s_enable_lost |=> !RUN_REQUEST_O;
    endproperty
    a_enable_lost: assert property (p_enable_lost) else $error("enable removal did not stop");

    property p_edge_held;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (mode == MSSC_MODE_EDGE && enable_rise && !run_reg) |=> !RUN_REQUEST_O;
    endproperty
    a_edge_held: assert property (p_edge_held) else $error("start at enable without edge");

    property p_level_none;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (mode == MSSC_MODE_LEVEL && !cmd.level_run_cw && !cmd.level_run_ccw) |=> !RUNNING_O;
    endproperty
    a_level_none: assert property (p_level_none) else $error("level mode ran with no command");

    property p_level_both;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (mode == MSSC_MODE_LEVEL && enable_rise && cmd.level_run_cw && cmd.level_run_ccw) |=> !RUNNING_O;
    endproperty
    a_level_both: assert property (p_level_both) else $error("both run inputs started motor");

    property p_drive_off;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        !cmd.drive_enable |=> !DRIVE_OUTPUT_EN_O && !RUN_REQUEST_O;
    endproperty
    a_drive_off: assert property (p_drive_off) else $error("drive not disabled");

    property p_conflict;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        conflict |=> CONFIG_ERROR_O && ERROR_CODE_O == MSSC_ERR_WIRING && !RUN_REQUEST_O;
    endproperty
    a_conflict: assert property (p_conflict) else $error("wiring error not flagged");

    property p_level_follow;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (mode == MSSC_MODE_LEVEL && enable && !enable_rise && drive_ok && lccw_rise && !lcw_rise)
            |=> RUN_REQUEST_O && (DIR_CCW_O == !$past(cmd.direction_invert));
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("latest run input not followed");

    property p_stop_pulse;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        STOP_ACTIVE_O |=> !STOP_ACTIVE_O;
    endproperty
    a_stop_pulse: assert property (p_stop_pulse) else $error("stop status longer than one cycle");

    property p_stop_method;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        cmd.drive_enable |=> STOP_METHOD_O == $past(STOP_METHOD_SELECT_I);
    endproperty
    a_stop_method: assert property (p_stop_method) else $error("stop method not passed on");

endmodule : mssc_core
`default_nettype wire

// *** mssc_operator.sv ***
// Operator switches and buttons that drive the command inputs
`timescale 1ns/1ps
`default_nettype none
module mssc_operator
    import mssc_pkg::*;
(
    input  wire logic       clk_i,
    output var  mssc_cmd_t  cmd_o
);
    // ----------------------------------------------------------------
    // Switch levels, changed only at the falling edge
    // ----------------------------------------------------------------
    initial cmd_o = '0;

    task set_levels(input logic [MSSC_NUM_CMD-1:0] lv);
        @(negedge clk_i);
        cmd_o = mssc_cmd_t'(lv);
    endtask : set_levels
endmodule : mssc_operator
`default_nettype wire

// *** motor_start_stop_command_logic_tb.sv ***
// Self-checking testbench for the motor start/stop command arbitration
`timescale 1ns/1ps
`default_nettype none
module motor_start_stop_command_logic_tb;
    import mssc_pkg::*;
    localparam logic [6:0] EN = 7'h40, RUN = 7'h20, ECW = 7'h10, ECCW = 7'h08;
    localparam logic [6:0] LCW = 7'h04, LCCW = 7'h02, INV = 7'h01;
    logic                       clk_sys;
    logic                       reset_n;
    logic                       edge_asg, level_asg, fault;
    logic [MSSC_STOP_SEL_W-1:0] stop_sel;
    mssc_cmd_t                  cmd;
    logic                       drv_en, run_req, dir_ccw, running, stop_act, dir_rev, cfg_err;
    logic [MSSC_STOP_SEL_W-1:0] stop_m;
    logic [15:0]                err_code;
    int                         num_errors, comparisons, stop_seen;

    // ----------------------------------------------------------------
    // Clock, far side and design
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    mssc_operator OP (.clk_i(clk_sys), .cmd_o(cmd));
    mssc_core DUT (.CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .DRIVE_ENABLE_I(cmd.drive_enable),
        .RUN_COMMAND_I(cmd.run_command), .EDGE_START_CW_I(cmd.edge_start_cw),
        .EDGE_START_CCW_I(cmd.edge_start_ccw), .LEVEL_RUN_CW_I(cmd.level_run_cw),
        .LEVEL_RUN_CCW_I(cmd.level_run_ccw), .DIRECTION_INVERT_I(cmd.direction_invert),
        .EDGE_ASSIGNED_I(edge_asg), .LEVEL_ASSIGNED_I(level_asg), .FAULT_ACTIVE_I(fault),
        .STOP_METHOD_SELECT_I(stop_sel), .DRIVE_OUTPUT_EN_O(drv_en), .RUN_REQUEST_O(run_req),
        .DIR_CCW_O(dir_ccw), .STOP_METHOD_O(stop_m), .RUNNING_O(running), .STOP_ACTIVE_O(stop_act),
        .DIR_REVERSED_O(dir_rev), .CONFIG_ERROR_O(cfg_err), .ERROR_CODE_O(err_code));

    // ----------------------------------------------------------------
    // Compare and drive helpers
    // ----------------------------------------------------------------
    task check_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask : check_bit

    task check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_word

    // Apply switch levels and let the three-edge latency pass, counting stop pulses
    task go(input logic [6:0] lv);
        stop_seen = 0;
        OP.set_levels(lv);
        repeat (5)
        begin
            @(negedge clk_sys);
            if (stop_act === 1'h1) stop_seen++;
        end
    endtask : go

    task chk_run(input logic r, input logic d);
        check_bit(run_req, r, "run request");
        check_bit(running, r, "running status");
        if (r) check_bit(dir_ccw, d, "direction");
    endtask : chk_run

    task set_cfg(input logic e, input logic l);
        @(negedge clk_sys);
        edge_asg = e;
        level_asg = l;
    endtask : set_cfg

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task test_single();
        set_cfg(1'h0, 1'h0);
        go(EN | RUN); chk_run(1'h1, 1'h0);
        go(EN | RUN | INV); chk_run(1'h1, 1'h1);
        check_bit(dir_rev, 1'h1, "reversed status");
        go(EN | RUN); chk_run(1'h1, 1'h0);
        check_bit(dir_rev, 1'h0, "reversed status");
        for (int m = 0; m < 4; m++)
        begin
            stop_sel = MSSC_STOP_SEL_W'(m);
            go(EN | RUN);
            go(EN); chk_run(1'h0, 1'h0);
            check_word(16'(stop_m), 16'(m), "stop method");
            check_word(16'(stop_seen), 16'h0001, "stop pulses");
        end
        go(EN | RUN);
        @(negedge clk_sys) fault = 1'h1;
        repeat (2) @(negedge clk_sys);
        chk_run(1'h0, 1'h0);
        @(negedge clk_sys) fault = 1'h0;
    endtask : test_single

    task test_drive_enable();
        stop_sel = MSSC_STOP_RAMP;
        go(EN | RUN); check_bit(drv_en, 1'h1, "drive output");
        go(RUN); check_bit(drv_en, 1'h0, "drive output");
        chk_run(1'h0, 1'h0);
        check_word(16'(stop_m), 16'(MSSC_STOP_COAST), "coast forced");
    endtask : test_drive_enable

    task test_edge();
        set_cfg(1'h1, 1'h0);
        go(EN); go(EN | RUN); chk_run(1'h0, 1'h0);
        OP.set_levels(EN | RUN | ECW);
        repeat (2) @(negedge clk_sys);
        chk_run(1'h0, 1'h0);
        @(negedge clk_sys); chk_run(1'h1, 1'h0);
        go(EN | RUN); chk_run(1'h1, 1'h0);
        go(EN | RUN | ECCW); chk_run(1'h1, 1'h1);
        go(EN); chk_run(1'h0, 1'h0);
        check_word(16'(stop_seen), 16'h0001, "stop pulses");
        go(EN | RUN); chk_run(1'h0, 1'h0);
        go(EN | ECW); go(EN | RUN | ECW); chk_run(1'h0, 1'h0);
        go(EN | RUN); go(EN | RUN | ECW); chk_run(1'h1, 1'h0);
        go(EN);
    endtask : test_edge

    task test_level();
        set_cfg(1'h0, 1'h1);
        go(EN | LCW); chk_run(1'h0, 1'h0);
        go(EN | RUN | LCW); chk_run(1'h1, 1'h0);
        go(EN | RUN | LCW | LCCW); chk_run(1'h1, 1'h1);
        go(EN | RUN | LCW); chk_run(1'h1, 1'h0);
        go(EN | RUN); chk_run(1'h0, 1'h0);
        go(EN | LCW | LCCW); go(EN | RUN | LCW | LCCW); chk_run(1'h0, 1'h0);
        go(EN | RUN | LCCW); chk_run(1'h1, 1'h1);
        go(EN | LCCW); chk_run(1'h0, 1'h0);
        go(EN); go(EN | RUN); chk_run(1'h0, 1'h0);
        go(EN | RUN | LCW); chk_run(1'h1, 1'h0);
    endtask : test_level

    task test_conflict();
        set_cfg(1'h1, 1'h1);
        go(EN | RUN | LCW); chk_run(1'h0, 1'h0);
        check_bit(cfg_err, 1'h1, "config error");
        check_word(err_code, MSSC_ERR_WIRING, "error code");
        set_cfg(1'h0, 1'h1);
        go(EN);
        check_bit(cfg_err, 1'h0, "config error");
        check_word(err_code, MSSC_ERR_NONE, "error code");
    endtask : test_conflict

    // ----------------------------------------------------------------
    // Verdict, sequence and watchdog
    // ----------------------------------------------------------------
    task results();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    initial
    begin
        reset_n = 1'h0;
        edge_asg = 1'h0;
        level_asg = 1'h0;
        fault = 1'h0;
        stop_sel = MSSC_STOP_COAST;
        num_errors = 0;
        comparisons = 0;
        repeat (20) @(negedge clk_sys);
        reset_n = 1'h1;
        test_single();
        test_drive_enable();
        test_edge();
        test_level();
        test_conflict();
        results();
    end

    initial
    begin
        #50000;
        num_errors++;
        results();
    end
endmodule : motor_start_stop_command_logic_tb
`default_nettype wire
